// ===== common/msg_fabric_map.vh
// constants for the thread message delivery fabric
// assumes a single 200 MHz clock and a plain register port
//
// Notes on behaviour
// - messages from a thread to one target leave in issue order.
// - different targets and writeback registers may complete in any order.
// - channel mask does not gate dispatch of a send.
// - implied register copy always moves exactly one register.
// - channel mask travels with the message to the target.
// - math uses enabled channels; render writes ignore mask, use payload mask.
// - immediate thread-end send stops the thread and marks it complete.
// - dispatcher and fixed functions watch every transmission for thread-end.
// - on thread-end the dispatcher frees the thread's resources.
// - fixed function acts only on thread-end carrying its own 4b id.
// - message register is 256 bits, dword 0 at [31:0], dword 7 at [255:224].
// - writeback register index is an offset from the starting destination.
// - fabric detects bad target ids and bad lengths; core does no checks.
// - each detected error is captured and raises an interrupt line, except a target report in the same cycle as a send error, which is lost.
// - bad-target message is dropped; its destinations stay in flight.
// - bad opcode or length latches sender, lengths, header; fabric continues; a target report latches zero in place of the sender id.
// - bad payload may be dropped; destinations then remain in flight.
// - thread-end send with non-null destination is refused; thread hangs.
// - thread-end flag honoured only for immediate descriptors.
// - a send marks its payload registers in flight until transmitted.
// - each writeback clears its destination register's in-flight flag.
`ifndef MSG_FABRIC_MAP_VH
`define MSG_FABRIC_MAP_VH

// target unit ids
`define TGT_NULL 4'h0
`define TGT_MATH 4'h1
`define TGT_SAMPLER 4'h2
`define TGT_GATEWAY 4'h3
`define TGT_MEM_READ 4'h4
`define TGT_MEM_WRITE 4'h5
`define TGT_RESULT_STORE 4'h6
`define TGT_LAUNCHER 4'h7
`define TGT_COUNT 8

// message geometry
`define REG_BITS 256
`define DWORD_BITS 32
`define MRF_REGS 16
`define GRF_REGS 128
`define MAX_MSG_LEN 4'hF

// header field: fixed-function id in dword 5 bits [27:24] of first register
`define FFID_LSB 184
`define FFID_W 4

// error codes
`define ERR_NONE 2'h0
`define ERR_BAD_TARGET 2'h1
`define ERR_BAD_LENGTH 2'h2
`define ERR_BAD_EOT 2'h3

// register map, word offsets
`define ADDR_ERR_STATUS 4'h0
`define ADDR_ERR_INFO 4'h1
`define ADDR_ERR_HEADER 4'h2
`define ADDR_CTRL 4'h3
`define ADDR_TGT_ENABLE 4'h4
`define ADDR_MSG_COUNT 4'h5
`define ADDR_GRF_FLIGHT_LO 4'h6
`define ADDR_MRF_FLIGHT 4'h7
`define CTRL_RESET 32'h0000_0001
`define TGT_ENABLE_RESET 32'h0000_00FF

`endif

// ===== logic/flight_tracker.v
// in-flight bit vector with set and clear masks
// assumes set and clear come from the same clock domain
`timescale 1ns/1ps
`default_nettype none

module flight_tracker #(
   parameter N = 16
) (
   input wire clk,
   input wire nrst,
   input wire [N-1:0] set_mask,
   input wire [N-1:0] clr_mask,
   output reg [N-1:0] flight_ff
);

   ////////////////////////////////////////////////////////////////
   // set wins over clear so a reissue in the release cycle holds
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flight_ff <= {N{1'b0}};
      end else begin
         flight_ff <= (flight_ff & ~clr_mask) | set_mask;
      end
   end

endmodule // flight_tracker

`default_nettype wire

// ===== logic/thread_message_delivery.v
// message delivery fabric: one issuing thread to the shared functions
// assumes the core holds send until accepted and handshakes per target
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "msg_fabric_map.vh"

module thread_message_delivery #(
   parameter NTGT = `TGT_COUNT,
   parameter MRFN = `MRF_REGS,
   parameter GRFN = `GRF_REGS
) (
   input wire clk,
   input wire nrst,
   // send request from execution core
   input wire send_valid,
   input wire [3:0] send_target_unit_id,
   input wire [3:0] send_mrf_start,
   input wire [3:0] send_msg_len,
   input wire [3:0] send_resp_len,
   input wire [6:0] send_dest_grf,
   input wire send_dest_null,
   input wire send_desc_immediate,
   input wire send_thread_end_flag,
   input wire [15:0] send_channel_enable_mask,
   input wire [`REG_BITS-1:0] send_header_reg,
   input wire [7:0] send_sender_id,
   output reg send_ready_ff,
   output reg thread_done_ff,
   output reg thread_hung_ff,
   // transmit towards the selected target
   output reg [NTGT-1:0] tx_valid_ff,
   input wire [NTGT-1:0] tx_ready,
   output reg [3:0] tx_msg_len_ff,
   output reg [3:0] tx_resp_len_ff,
   output reg [15:0] tx_channel_enable_mask_ff,
   output reg [`REG_BITS-1:0] tx_header_ff,
   output reg tx_thread_end_flag_ff,
   // snoop for dispatcher and fixed functions
   output reg snoop_thread_end_ff,
   output reg [3:0] snoop_ffid_ff,
   output reg dispatcher_release_ff,
   // writeback from shared functions
   input wire wb_valid,
   input wire [3:0] wb_index,
   input wire [6:0] wb_base,
   output reg [GRFN-1:0] grf_flight_ff,
   output reg [MRFN-1:0] mrf_flight_ff,
   // shared function error report
   input wire sf_err_valid,
   input wire [3:0] sf_err_target,
   // register port
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_ff,
   output reg err_irq_ff
);

   localparam ST_IDLE = 3'b001;
   localparam ST_SEND = 3'b010;
   localparam ST_DONE = 3'b100;

   ////////////////////////////////////////////////////////////////
   // decoding used by the checks and the in-flight masks
   function eot_target_ok;
      input [3:0] t;
      begin
         eot_target_ok = (t == `TGT_MEM_WRITE) || (t == `TGT_RESULT_STORE) ||
                         (t == `TGT_GATEWAY) || (t == `TGT_LAUNCHER) || (t == `TGT_NULL);
      end
   endfunction

   function [MRFN-1:0] range_mask;
      input [3:0] start;
      input [3:0] len;
      integer i;
      begin
         range_mask = {MRFN{1'b0}};
         for (i = 0; i < MRFN; i = i + 1) begin
            if ((i >= start) && (i < start + len)) begin
               range_mask[i] = 1'b1;
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // state and software registers
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [3:0] tgt_ff;
   reg [3:0] mrf_start_ff;
   reg [3:0] msg_len_ff;
   reg [1:0] err_code_ff;
   reg [15:0] err_sender_ff;
   reg [7:0] err_lens_ff;
   reg [31:0] err_header_ff;
   reg [31:0] ctrl_ff;
   reg [31:0] tgt_enable_ff;
   reg [31:0] msg_count_ff;
   reg [MRFN-1:0] mrf_set;
   reg [MRFN-1:0] mrf_clr;
   reg [GRFN-1:0] grf_set;
   reg [GRFN-1:0] grf_clr;
   wire [MRFN-1:0] mrf_flight;
   wire [GRFN-1:0] grf_flight;
   wire fabric_en;
   wire bad_target;
   wire bad_length;
   wire eot_honoured;
   wire eot_refused;
   wire accept;
   wire tx_fire;
   wire [6:0] wb_reg;

   assign fabric_en = ctrl_ff[0];
   // the core does no validation, so the fabric checks everything it can
   assign bad_target = (send_target_unit_id >= NTGT) ||
                       !tgt_enable_ff[send_target_unit_id[2:0]];
   assign bad_length = (send_msg_len == 4'h0) ||
                       ({1'b0, send_mrf_start} + {1'b0, send_msg_len} > 5'd16);
   // register-sourced descriptors never end the thread
   assign eot_honoured = send_thread_end_flag && send_desc_immediate;
   assign eot_refused = eot_honoured && (!send_dest_null ||
                        !eot_target_ok(send_target_unit_id));
   // the channel mask plays no part in accepting a send
   assign accept = send_valid && send_ready_ff && !eot_refused;
   assign tx_fire = |(tx_valid_ff & tx_ready);
   assign wb_reg = wb_base + {3'b000, wb_index};

   ////////////////////////////////////////////////////////////////
   // in-flight masks
   always @* begin
      mrf_set = {MRFN{1'b0}};
      mrf_clr = {MRFN{1'b0}};
      grf_set = {GRFN{1'b0}};
      grf_clr = {GRFN{1'b0}};
      if (accept) begin
         mrf_set = range_mask(send_mrf_start, send_msg_len);
         if (!send_dest_null) begin
            // dropped messages never clear these: thread hangs on use
            grf_set = {{(GRFN-16){1'b0}}, range_mask(4'h0, send_resp_len)} << send_dest_grf;
         end
      end
      if (state_ff == ST_DONE) begin
         mrf_clr = range_mask(mrf_start_ff, msg_len_ff);
      end
      if (wb_valid) begin
         grf_clr[wb_reg] = 1'b1;
      end
   end

   flight_tracker #(.N(MRFN)) u_mrf_flight (
      .clk(clk),
      .nrst(nrst),
      .set_mask(mrf_set),
      .clr_mask(mrf_clr),
      .flight_ff(mrf_flight)
   );

   flight_tracker #(.N(GRFN)) u_grf_flight (
      .clk(clk),
      .nrst(nrst),
      .set_mask(grf_set),
      .clr_mask(grf_clr),
      .flight_ff(grf_flight)
   );

   ////////////////////////////////////////////////////////////////
   // next state: one message at a time keeps per-target order
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (accept && !bad_target && !bad_length) begin
               nxt_state = ST_SEND;
            end
         end
         ST_SEND: begin
            if (tx_fire) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // message path, snoop and thread control
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
         send_ready_ff <= 1'b0;
         thread_done_ff <= 1'b0;
         thread_hung_ff <= 1'b0;
         tx_valid_ff <= {NTGT{1'b0}};
         tx_msg_len_ff <= 4'h0;
         tx_resp_len_ff <= 4'h0;
         tx_channel_enable_mask_ff <= 16'h0000;
         tx_header_ff <= {`REG_BITS{1'b0}};
         tx_thread_end_flag_ff <= 1'b0;
         snoop_thread_end_ff <= 1'b0;
         snoop_ffid_ff <= 4'h0;
         dispatcher_release_ff <= 1'b0;
         tgt_ff <= 4'h0;
         mrf_start_ff <= 4'h0;
         msg_len_ff <= 4'h0;
         grf_flight_ff <= {GRFN{1'b0}};
         mrf_flight_ff <= {MRFN{1'b0}};
      end else begin
         state_ff <= nxt_state;
         grf_flight_ff <= grf_flight;
         mrf_flight_ff <= mrf_flight;
         snoop_thread_end_ff <= 1'b0;
         dispatcher_release_ff <= 1'b0;
         send_ready_ff <= fabric_en && !thread_done_ff && !thread_hung_ff &&
                          (nxt_state == ST_IDLE);
         if (send_valid && send_ready_ff && eot_refused) begin
            thread_hung_ff <= 1'b1;
         end
         if (accept) begin
            tgt_ff <= send_target_unit_id;
            mrf_start_ff <= send_mrf_start;
            msg_len_ff <= send_msg_len;
            tx_msg_len_ff <= send_msg_len;
            tx_resp_len_ff <= send_resp_len;
            tx_channel_enable_mask_ff <= send_channel_enable_mask;
            tx_header_ff <= send_header_reg;
            tx_thread_end_flag_ff <= eot_honoured;
            if (eot_honoured) begin
               thread_done_ff <= 1'b1;
            end
            if (!bad_target && !bad_length) begin
               tx_valid_ff <= {{(NTGT-1){1'b0}}, 1'b1} << send_target_unit_id[2:0];
            end
         end
         if (tx_fire) begin
            tx_valid_ff <= {NTGT{1'b0}};
            // every transmission is snooped regardless of target
            snoop_thread_end_ff <= tx_thread_end_flag_ff;
            snoop_ffid_ff <= tx_header_ff[`FFID_LSB +: `FFID_W];
            dispatcher_release_ff <= tx_thread_end_flag_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // error capture, set wins over a software clear
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         err_code_ff <= `ERR_NONE;
         err_sender_ff <= 16'h0000;
         err_lens_ff <= 8'h00;
         err_header_ff <= 32'h0000_0000;
         err_irq_ff <= 1'b0;
         msg_count_ff <= 32'h0000_0000;
      end else begin
         if (reg_wr && (reg_addr == `ADDR_ERR_STATUS) && reg_wdata[0]) begin
            err_irq_ff <= 1'b0;
            err_code_ff <= `ERR_NONE;
         end
         if (tx_fire) begin
            msg_count_ff <= msg_count_ff + 32'h0000_0001;
         end
         if (accept && (bad_target || bad_length)) begin
            err_code_ff <= bad_target ? `ERR_BAD_TARGET : `ERR_BAD_LENGTH;
            err_sender_ff <= {4'h0, send_target_unit_id, send_sender_id};
            err_lens_ff <= {send_msg_len, send_resp_len};
            err_header_ff <= send_header_reg[31:0];
            err_irq_ff <= 1'b1;
         end else if (send_valid && send_ready_ff && eot_refused) begin
            err_code_ff <= `ERR_BAD_EOT;
            err_sender_ff <= {4'h0, send_target_unit_id, send_sender_id};
            err_lens_ff <= {send_msg_len, send_resp_len};
            err_header_ff <= send_header_reg[31:0];
            err_irq_ff <= 1'b1;
         end else if (sf_err_valid) begin
            // target reports; fabric keeps going with the next message
            err_code_ff <= `ERR_BAD_LENGTH;
            err_sender_ff <= {4'h0, sf_err_target, 8'h00};
            err_lens_ff <= {tx_msg_len_ff, tx_resp_len_ff};
            err_header_ff <= tx_header_ff[31:0];
            err_irq_ff <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // software registers and read port
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= `CTRL_RESET;
         tgt_enable_ff <= `TGT_ENABLE_RESET;
         reg_rdata_ff <= 32'h0000_0000;
      end else begin
         if (reg_wr && (reg_addr == `ADDR_CTRL)) begin
            ctrl_ff <= {31'h0000_0000, reg_wdata[0]};
         end
         if (reg_wr && (reg_addr == `ADDR_TGT_ENABLE)) begin
            tgt_enable_ff <= {24'h00_0000, reg_wdata[7:0]};
         end
         reg_rdata_ff <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               `ADDR_ERR_STATUS: reg_rdata_ff <= {29'h0000_0000, err_code_ff, err_irq_ff};
               `ADDR_ERR_INFO: reg_rdata_ff <= {err_lens_ff, 8'h00, err_sender_ff[15:0]};
               `ADDR_ERR_HEADER: reg_rdata_ff <= err_header_ff;
               `ADDR_CTRL: reg_rdata_ff <= ctrl_ff;
               `ADDR_TGT_ENABLE: reg_rdata_ff <= tgt_enable_ff;
               `ADDR_MSG_COUNT: reg_rdata_ff <= msg_count_ff;
               `ADDR_GRF_FLIGHT_LO: reg_rdata_ff <= grf_flight_ff[31:0];
               `ADDR_MRF_FLIGHT: reg_rdata_ff <= {16'h0000, mrf_flight_ff};
               default: reg_rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // thread_message_delivery

`default_nettype wire

// ===== verification/thread_message_delivery_properties.sv
// checker on the fabric's send, transmit and snoop ports
// assumes the bench keeps lengths legal and target enables at reset value
`timescale 1ns/1ps
`default_nettype none
module thread_message_delivery_properties #(
   parameter NTGT = 8
) (
   input wire clk,
   input wire nrst,
   input wire send_valid,
   input wire [3:0] send_target_unit_id,
   input wire send_dest_null,
   input wire send_desc_immediate,
   input wire send_thread_end_flag,
   input wire [15:0] send_channel_enable_mask,
   input wire send_ready_ff,
   input wire thread_done_ff,
   input wire thread_hung_ff,
   input wire [NTGT-1:0] tx_valid_ff,
   input wire [NTGT-1:0] tx_ready,
   input wire [15:0] tx_channel_enable_mask_ff,
   input wire tx_thread_end_flag_ff,
   input wire snoop_thread_end_ff,
   input wire dispatcher_release_ff,
   input wire err_irq_ff
);
   // accept and transmit handshakes
   wire acc = send_valid && send_ready_ff;
   wire hs = |(tx_valid_ff & tx_ready);
   wire good = send_target_unit_id < 4'h8;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////////
   chk_mask_forward: assert property (acc && !send_thread_end_flag && good |=>
      tx_valid_ff == ({{(NTGT-1){1'b0}}, 1'b1} << $past(send_target_unit_id))
      && tx_channel_enable_mask_ff == $past(send_channel_enable_mask)) else $error("mask or target lost");
   chk_tx_hold: assert property (tx_valid_ff != 0 && !hs |=> $stable(tx_valid_ff)
      && $stable(tx_channel_enable_mask_ff)) else $error("transmit changed before taken");
   chk_snoop_any: assert property (hs && tx_thread_end_flag_ff |=>
      snoop_thread_end_ff && dispatcher_release_ff) else $error("thread end not snooped");
   chk_snoop_cause: assert property (snoop_thread_end_ff |->
      $past(hs && tx_thread_end_flag_ff)) else $error("snoop without thread end");
   chk_eot_done: assert property (acc && send_thread_end_flag && send_desc_immediate && send_dest_null
      && good |-> ##[1:20] thread_done_ff) else $error("thread end not completed");
   chk_eot_refuse: assert property (acc && send_thread_end_flag && send_desc_immediate && !send_dest_null
      |=> tx_valid_ff == 0 ##[0:2] (thread_hung_ff && err_irq_ff)) else $error("bad thread end issued");
   chk_reg_desc: assert property (acc && send_thread_end_flag && !send_desc_immediate |=>
      !tx_thread_end_flag_ff && !thread_done_ff) else $error("register descriptor ended thread");
   chk_bad_drop: assert property (acc && !send_thread_end_flag && !good |=>
      tx_valid_ff == 0 ##[0:2] err_irq_ff) else $error("bad target not dropped");
   chk_done_stop: assert property (thread_done_ff && $past(thread_done_ff) |->
      !send_ready_ff) else $error("ended thread still sends");
   // main scenarios reached
   cov_eot: cover property (hs && tx_thread_end_flag_ff);
   cov_stall: cover property (tx_valid_ff != 0 && !hs ##1 hs);
   cov_irq: cover property ($rose(err_irq_ff));
endmodule // thread_message_delivery_properties
bind thread_message_delivery thread_message_delivery_properties #(.NTGT(NTGT)) i_props (.clk, .nrst,
   .send_valid, .send_target_unit_id, .send_dest_null, .send_desc_immediate, .send_thread_end_flag,
   .send_channel_enable_mask, .send_ready_ff, .thread_done_ff, .thread_hung_ff, .tx_valid_ff, .tx_ready,
   .tx_channel_enable_mask_ff, .tx_thread_end_flag_ff, .snoop_thread_end_ff, .dispatcher_release_ff, .err_irq_ff);
`default_nettype wire

// ===== verification/shared_function_model.sv
// model of the shared functions on the fabric's transmit side
// assumes the bench sets stall and calls the writeback and error tasks
`timescale 1ns/1ps
`default_nettype none
module shared_function_model (
   input wire clk,
   input wire nrst,
   input wire [7:0] tx_valid_ff,
   output logic [7:0] tx_ready,
   output logic wb_valid,
   output logic [3:0] wb_index,
   output logic [6:0] wb_base,
   output logic sf_err_valid,
   output logic [3:0] sf_err_target
);
   int stall = 0;
   int wait_cnt;
   initial begin
      wb_valid = 1'b0;
      wb_index = 4'h0;
      wb_base = 7'h00;
      sf_err_valid = 1'b0;
      sf_err_target = 4'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // take each message after stall idle cycles, one-cycle ready pulse
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_ready <= 8'h00;
         wait_cnt <= 0;
      end else if (tx_ready != 8'h00 || tx_valid_ff == 8'h00) begin
         tx_ready <= 8'h00;
         wait_cnt <= 0;
      end else if (wait_cnt >= stall) begin
         tx_ready <= tx_valid_ff;
      end else begin
         wait_cnt <= wait_cnt + 1;
      end
   end
   // registers may come back in any order, the bench picks it
   task automatic write_back(input logic [6:0] base, input logic [3:0] idx);
      @(posedge clk);
      wb_valid <= 1'b1;
      wb_base <= base;
      wb_index <= idx;
      @(posedge clk);
      wb_valid <= 1'b0;
      wb_base <= ~base; // released lines show no stale value
      wb_index <= ~idx;
   endtask
   // bad opcode or payload: report and drop, no writeback follows
   task automatic report_err(input logic [3:0] tgt);
      @(posedge clk);
      sf_err_valid <= 1'b1;
      sf_err_target <= tgt;
      @(posedge clk);
      sf_err_valid <= 1'b0;
      sf_err_target <= ~tgt;
   endtask
endmodule // shared_function_model
`default_nettype wire

// ===== verification/thread_message_delivery_tb.sv
// bench for the message fabric: sends, writebacks, errors, thread end
// assumes the shared function model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "msg_fabric_map.vh"
module thread_message_delivery_tb;
   logic clk, nrst, send_valid, send_dest_null, send_desc_immediate, send_thread_end_flag, reg_wr, reg_rd;
   logic [3:0] send_target_unit_id, send_mrf_start, send_msg_len, send_resp_len, reg_addr;
   logic [6:0] send_dest_grf;
   logic [15:0] send_channel_enable_mask;
   logic [`REG_BITS-1:0] send_header_reg;
   logic [7:0] send_sender_id;
   logic [31:0] reg_wdata;
   wire send_ready_ff, thread_done_ff, thread_hung_ff, tx_thread_end_flag_ff, snoop_thread_end_ff;
   wire dispatcher_release_ff, wb_valid, sf_err_valid, err_irq_ff;
   wire [7:0] tx_valid_ff, tx_ready;
   wire [3:0] tx_msg_len_ff, tx_resp_len_ff, snoop_ffid_ff, wb_index, sf_err_target;
   wire [15:0] tx_channel_enable_mask_ff, mrf_flight_ff;
   wire [`REG_BITS-1:0] tx_header_ff;
   wire [6:0] wb_base;
   wire [`GRF_REGS-1:0] grf_flight_ff;
   wire [31:0] reg_rdata_ff;
   int err_count = 0;
   int total_checks = 0;
   thread_message_delivery i_thread_message_delivery (.clk, .nrst, .send_valid, .send_target_unit_id,
      .send_mrf_start, .send_msg_len, .send_resp_len, .send_dest_grf, .send_dest_null, .send_desc_immediate,
      .send_thread_end_flag, .send_channel_enable_mask, .send_header_reg, .send_sender_id, .send_ready_ff,
      .thread_done_ff, .thread_hung_ff, .tx_valid_ff, .tx_ready, .tx_msg_len_ff, .tx_resp_len_ff,
      .tx_channel_enable_mask_ff, .tx_header_ff, .tx_thread_end_flag_ff, .snoop_thread_end_ff, .snoop_ffid_ff,
      .dispatcher_release_ff, .wb_valid, .wb_index, .wb_base, .grf_flight_ff, .mrf_flight_ff, .sf_err_valid,
      .sf_err_target, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .err_irq_ff);
   shared_function_model i_sf (.clk, .nrst, .tx_valid_ff, .tx_ready, .wb_valid, .wb_index, .wb_base,
      .sf_err_valid, .sf_err_target);
   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      report_and_stop;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic do_reset;
      nrst <= 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
   endtask
   // register port: one-cycle strobes, read data the cycle after
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk("register", exp, reg_rdata_ff);
   endtask
   // hold the send until the fabric shows ready
   task automatic send(input logic [3:0] tgt, input logic [15:0] mask, input logic thread_end_flag, input logic imm,
         input logic nul, input logic [6:0] general_register_file, input logic [3:0] rlen);
      int n;
      n = 0;
      @(posedge clk);
      send_target_unit_id <= tgt;
      send_channel_enable_mask <= mask;
      send_thread_end_flag <= thread_end_flag;
      send_desc_immediate <= imm;
      send_dest_null <= nul;
      send_dest_grf <= general_register_file;
      send_resp_len <= rlen;
      send_valid <= 1'b1;
      do @(negedge clk); while (send_ready_ff !== 1'b1 && ++n < 50);
      @(posedge clk);
      send_valid <= 1'b0;
   endtask
   task automatic see_tx(input logic [3:0] tgt, input logic [15:0] mask, input logic thread_end_flag);
      int n;
      n = 0;
      while (tx_valid_ff === 8'h00 && n++ < 50) @(negedge clk);
      chk("tx target", 8'h01 << tgt, tx_valid_ff);
      chk("tx mask", mask, tx_channel_enable_mask_ff);
      chk("tx end flag", thread_end_flag, tx_thread_end_flag_ff);
      chk("tx length", 4'h1, tx_msg_len_ff);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int n;
      {nrst, send_valid, send_dest_null, send_desc_immediate, send_thread_end_flag, reg_wr, reg_rd} = 7'h00;
      {send_target_unit_id, send_resp_len, reg_addr, send_dest_grf, send_channel_enable_mask} = 35'h0;
      send_mrf_start = 4'h2;
      send_msg_len = 4'h1;
      send_sender_id = 8'h3C;
      reg_wdata = 32'h0;
      send_header_reg = {`REG_BITS{1'b0}};
      send_header_reg[`FFID_LSB +: `FFID_W] = 4'h5;
      do_reset;
      reg_check(`ADDR_CTRL, `CTRL_RESET);
      reg_check(`ADDR_TGT_ENABLE, `TGT_ENABLE_RESET);
      reg_check(4'hA, 32'h0);
      $display("test reset values done");
      i_sf.stall = 3;
      send(`TGT_MATH, 16'hA5C3, 1'b0, 1'b1, 1'b1, 7'h00, 4'h0);
      see_tx(`TGT_MATH, 16'hA5C3, 1'b0);
      @(negedge clk);
      chk("payload in flight", 16'h0004, mrf_flight_ff);
      n = 0;
      while (mrf_flight_ff !== 16'h0000 && n++ < 20) @(negedge clk);
      chk("payload released", 16'h0000, mrf_flight_ff);
      i_sf.stall = 0;
      send(`TGT_MATH, 16'h0000, 1'b0, 1'b1, 1'b1, 7'h00, 4'h0);
      see_tx(`TGT_MATH, 16'h0000, 1'b0);
      repeat (3) @(negedge clk);
      reg_check(`ADDR_MSG_COUNT, 32'h2);
      $display("test ordered sends done");
      send(`TGT_SAMPLER, 16'hFFFF, 1'b0, 1'b1, 1'b0, 7'h0A, 4'h2);
      see_tx(`TGT_SAMPLER, 16'hFFFF, 1'b0);
      @(negedge clk);
      chk("dest in flight", 2'b11, grf_flight_ff[11:10]);
      i_sf.write_back(7'h0A, 4'h1);
      repeat (3) @(negedge clk);
      chk("second reg back", 2'b01, grf_flight_ff[11:10]);
      i_sf.write_back(7'h0A, 4'h0);
      repeat (3) @(negedge clk);
      chk("all regs back", 2'b00, grf_flight_ff[11:10]);
      $display("test writeback done");
      send(4'h9, 16'h1234, 1'b0, 1'b1, 1'b0, 7'h20, 4'h1);
      repeat (3) @(negedge clk);
      chk("bad target irq", 1'b1, err_irq_ff);
      chk("bad target dropped", 8'h00, tx_valid_ff);
      chk("dest stays in flight", 1'b1, grf_flight_ff[32]);
      reg_check(`ADDR_ERR_STATUS, 32'h3);
      reg_write(`ADDR_ERR_STATUS, 32'h1);
      reg_check(`ADDR_ERR_STATUS, 32'h0);
      i_sf.report_err(`TGT_MATH);
      repeat (3) @(negedge clk);
      reg_check(`ADDR_ERR_STATUS, 32'h5);
      reg_write(`ADDR_ERR_STATUS, 32'h1);
      $display("test errors done");
      send(`TGT_MEM_WRITE, 16'h00FF, 1'b1, 1'b0, 1'b1, 7'h00, 4'h0);
      see_tx(`TGT_MEM_WRITE, 16'h00FF, 1'b0);
      repeat (4) @(negedge clk);
      chk("still running", 1'b0, thread_done_ff);
      send(`TGT_MEM_WRITE, 16'h00FF, 1'b1, 1'b1, 1'b0, 7'h40, 4'h1);
      repeat (3) @(negedge clk);
      chk("refused end hangs", 1'b1, thread_hung_ff);
      reg_check(`ADDR_ERR_STATUS, 32'h7);
      $display("test register descriptor and refusal done");
      do_reset;
      send(`TGT_MEM_WRITE, 16'h0F0F, 1'b1, 1'b1, 1'b1, 7'h00, 4'h0);
      see_tx(`TGT_MEM_WRITE, 16'h0F0F, 1'b1);
      n = 0;
      while (snoop_thread_end_ff !== 1'b1 && n++ < 20) @(negedge clk);
      chk("snoop id", 4'h5, snoop_ffid_ff);
      chk("dispatcher release", 1'b1, dispatcher_release_ff);
      repeat (3) @(negedge clk);
      chk("thread done", 1'b1, thread_done_ff);
      chk("no further sends", 1'b0, send_ready_ff);
      $display("test thread end done");
      do_reset;
      send(`TGT_LAUNCHER, 16'h0001, 1'b1, 1'b1, 1'b1, 7'h00, 4'h0);
      see_tx(`TGT_LAUNCHER, 16'h0001, 1'b1);
      $display("test launcher end done");
      report_and_stop;
   end
endmodule // thread_message_delivery_tb
`default_nettype wire
